//--- logic/isd_defines.vh
// Constants of the input source detect sequencer
// Operation
// - Accept the supply only below overvoltage and not weak under the test load.
// - A passing qualification sets power-good and pulses the host interrupt; no pulse if power-good was already set.
// - A weak source is rechecked at a fixed retry interval until it passes.
// - Detection runs on every attach unless held high-impedance in host mode.
// - After detection software may rewrite the input limit field; it is applied.
// - Data contact detection starts only with supply present and power-good set.
// - Contact detect enables D+ source and D- pull-down, waits bounded for D+ low.
// - Primary detect drives D+ source, D- sink; low D- host, high D- port.
// - Contact timeout with floating lines selects 100 mA and source code 00.
// - Host gives code 01 with 100/500 mA by boost pin; port gives 10, 1.5 A.
// - Low-current host with good battery enters high-impedance and sets its bit.
// - In host mode high-impedance holds until software writes the bit to zero.
// - In default mode removal clears the high-impedance bit; next attach redetects.
// - Force-detection bit reruns detection and clears itself when detection ends.
// - After the limit is set the converter runs; battery switch off if charge disabled.
// - Below soft-start rail level force 100 mA, else lower of register and pin.
// - Boost needs battery level, low VBUS, pin high, config 10 and a delay.
// - While boosting the source type field reads all ones.
// - Minimum system voltage comes from a three-bit field with a default.
// - Status bit follows minimum system voltage regulation.
// - Reset returns every register to default and the bus is usable.
`ifndef ISD_DEFINES_VH
`define ISD_DEFINES_VH
// Clock rate in kHz, times in ms, qualification settle in cycles
`define ISD_CLK_KHZ 200000
`define ISD_RETRY_MS 2000
`define ISD_DCD_MIN_MS 40
`define ISD_DCD_MAX_MS 500
`define ISD_PRIM_MS 40
`define ISD_BOOST_MS 220
`define ISD_QUAL_SETTLE 32'h0000_0008
// Register byte offsets
`define ISD_OFS_INPUT 8'h00
`define ISD_OFS_POWER 8'h04
`define ISD_OFS_MISC 8'h08
`define ISD_OFS_STATUS 8'h0C
// Field positions
`define ISD_HIZ_BIT 7
`define ISD_LIM_MSB 2
`define ISD_CFG_MSB 5
`define ISD_CFG_LSB 4
`define ISD_MINSYS_MSB 3
`define ISD_MINSYS_LSB 1
`define ISD_LOWBAT_BIT 0
`define ISD_FORCE_BIT 7
`define ISD_HOSTMODE_BIT 0
`define ISD_SRC_MSB 7
`define ISD_SRC_LSB 6
`define ISD_PG_BIT 2
`define ISD_BOOST_BIT 1
`define ISD_MINREG_BIT 0
// Input limit codes
`define ISD_LIM_100 3'h0
`define ISD_LIM_500 3'h2
`define ISD_LIM_1500 3'h5
// Source type codes
`define ISD_SRC_NONE 2'h0
`define ISD_SRC_HOST 2'h1
`define ISD_SRC_PORT 2'h2
`define ISD_SRC_BOOST 2'h3
// Charge configuration codes
`define ISD_CFG_CHARGE 2'h1
`define ISD_CFG_BOOST 2'h2
// Reset values
`define ISD_RST_LIM 3'h0
`define ISD_RST_CFG 2'h1
`define ISD_RST_MINSYS 3'h5
`endif

//--- logic/isd_timer.v
// Saturating cycle counter used for all sequencer intervals
`timescale 1ns/10ps
`default_nettype none
module isd_timer (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Control
  input wire clr,
  // Count
  output reg [31:0] cnt_r
);
  // Saturation keeps a long wait from wrapping into a false early timeout
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 32'h0000_0000;
    end else if (clr) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r != 32'hFFFF_FFFF) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
endmodule // isd_timer
`default_nettype wire

//--- logic/isd_input_detect.v
// Input source qualification, D+/D- detection and limit sequencer
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "isd_defines.vh"
module isd_input_detect #(
  parameter [31:0] RETRY_CYC = `ISD_RETRY_MS * `ISD_CLK_KHZ,
  parameter [31:0] DCD_MIN_CYC = `ISD_DCD_MIN_MS * `ISD_CLK_KHZ,
  parameter [31:0] DCD_MAX_CYC = `ISD_DCD_MAX_MS * `ISD_CLK_KHZ,
  parameter [31:0] PRIM_CYC = `ISD_PRIM_MS * `ISD_CLK_KHZ,
  parameter [31:0] BOOST_CYC = `ISD_BOOST_MS * `ISD_CLK_KHZ
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Supply comparators
  input wire vbusPresent,
  input wire vbusOverVolt,
  input wire vbusWeak,
  input wire vbusBelowSleep,
  input wire batAboveGood,
  input wire batAboveLowA,
  input wire batAboveLowB,
  input wire sysBelowSoftStart,
  input wire sysInMinReg,
  // Data line comparators
  input wire dpLow,
  input wire dmHigh,
  // Pins
  input wire boostRequestPin,
  input wire [2:0] currentLimitPin,
  // Analog controls
  output reg testLoadEn_r,
  output reg dpSrcEn_r,
  output reg dmPullDnEn_r,
  output reg dpVoltSrcEn_r,
  output reg dmSinkEn_r,
  output reg regulatorEn_r,
  output reg converterEn_r,
  output reg batterySwitchOn_r,
  output reg boostEn_r,
  output reg [2:0] inputLimit_r,
  output reg [2:0] minSysSel_r,
  // Host notification
  output reg hostInt_r
);
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_QUAL = 8'h02;
  localparam [7:0] ST_RETRY = 8'h04;
  localparam [7:0] ST_DCD = 8'h08;
  localparam [7:0] ST_PRIM = 8'h10;
  localparam [7:0] ST_RUN = 8'h20;
  localparam [7:0] ST_HIZ = 8'h40;
  localparam [7:0] ST_BOOST = 8'h80;
  // States that end when the supply goes away
  localparam [7:0] ATTACH_MASK = 8'h3E;

  reg [7:0] state_r;
  reg [7:0] stateNxt;
  reg hizCtrl_r;
  reg [2:0] limitField_r;
  reg [1:0] chgCfg_r;
  reg [2:0] minSys_r;
  reg lowBatSel_r;
  reg forceDet_r;
  reg hostMode_r;
  reg pgood_r;
  reg [1:0] srcType_r;
  reg minSysReg_r;
  reg [2:0] statusPrev_r;
  reg detDone;
  reg detHiz;
  reg qualPass;
  reg [1:0] detCode;
  reg [2:0] detLimit;
  reg [1:0] srcTypeNxt;
  reg [2:0] pinOrReg;
  reg [31:0] rdVal;
  reg mapped;
  wire [31:0] tmrCnt;
  wire tmrClr;
  wire wrEn;
  wire batLowOk;
  wire boostOk;
  wire chgEn;

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer
  // Outside idle the timer restarts on every state change; in idle it only
  // runs while the boost conditions hold, so the delay is continuous
  assign tmrClr = (stateNxt != state_r) || ((state_r == ST_IDLE) && !boostOk);
  isd_timer u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(tmrClr),
    .cnt_r(tmrCnt)
  );

  assign batLowOk = lowBatSel_r ? batAboveLowB : batAboveLowA;
  assign boostOk = batLowOk && vbusBelowSleep && boostRequestPin &&
                   (chgCfg_r == `ISD_CFG_BOOST);
  assign chgEn = (chgCfg_r == `ISD_CFG_CHARGE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    stateNxt = state_r;
    detDone = 1'b0;
    detHiz = 1'b0;
    qualPass = 1'b0;
    detCode = srcType_r;
    detLimit = limitField_r;
    case (state_r)
      ST_IDLE: begin
        if (vbusPresent && !vbusBelowSleep) begin
          if (hizCtrl_r && hostMode_r) begin
            stateNxt = ST_HIZ;
          end else begin
            stateNxt = ST_QUAL;
          end
        end else if (boostOk && (tmrCnt >= BOOST_CYC)) begin
          stateNxt = ST_BOOST;
        end
      end
      ST_QUAL: begin
        // Overvoltage simply holds here until the supply drops back
        if (tmrCnt >= `ISD_QUAL_SETTLE) begin
          if (vbusWeak) begin
            stateNxt = ST_RETRY;
          end else if (!vbusOverVolt) begin
            qualPass = 1'b1;
            stateNxt = ST_DCD;
          end
        end
      end
      ST_RETRY: begin
        if (tmrCnt >= RETRY_CYC) begin
          stateNxt = ST_QUAL;
        end
      end
      ST_DCD: begin
        if ((tmrCnt >= DCD_MIN_CYC) && dpLow) begin
          stateNxt = ST_PRIM;
        end else if (tmrCnt >= DCD_MAX_CYC) begin
          detDone = 1'b1;
          detCode = `ISD_SRC_NONE;
          detLimit = `ISD_LIM_100;
          stateNxt = ST_RUN;
        end
      end
      ST_PRIM: begin
        if (tmrCnt >= PRIM_CYC) begin
          detDone = 1'b1;
          if (dmHigh) begin
            detCode = `ISD_SRC_PORT;
            detLimit = `ISD_LIM_1500;
            stateNxt = ST_RUN;
          end else begin
            detCode = `ISD_SRC_HOST;
            detLimit = boostRequestPin ? `ISD_LIM_500 : `ISD_LIM_100;
            if (!boostRequestPin && batAboveGood) begin
              detHiz = 1'b1;
              stateNxt = ST_HIZ;
            end else begin
              stateNxt = ST_RUN;
            end
          end
        end
      end
      ST_RUN: begin
        if (hizCtrl_r) begin
          stateNxt = ST_HIZ;
        end else if (forceDet_r) begin
          stateNxt = ST_DCD;
        end
      end
      ST_HIZ: begin
        if (!hizCtrl_r) begin
          stateNxt = vbusPresent ? ST_QUAL : ST_IDLE;
        end
      end
      ST_BOOST: begin
        if (!boostOk) begin
          stateNxt = ST_IDLE;
        end
      end
      default: begin
        stateNxt = ST_IDLE;
      end
    endcase
    if (!vbusPresent && ((state_r & ATTACH_MASK) != 8'h00)) begin
      stateNxt = ST_IDLE;
    end
  end

  // Source type: boost overrides, leaving boost clears, detection reports
  always @* begin
    srcTypeNxt = srcType_r;
    if (stateNxt == ST_BOOST) begin
      srcTypeNxt = `ISD_SRC_BOOST;
    end else if (state_r == ST_BOOST) begin
      srcTypeNxt = `ISD_SRC_NONE;
    end else if (detDone) begin
      srcTypeNxt = detCode;
    end
  end

  // Limit codes rise with current, so the lower code is the lower limit
  always @* begin
    if (limitField_r < currentLimitPin) begin
      pinOrReg = limitField_r;
    end else begin
      pinOrReg = currentLimitPin;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      pgood_r <= 1'b0;
      srcType_r <= `ISD_SRC_NONE;
      minSysReg_r <= 1'b0;
      statusPrev_r <= 3'h0;
      hostInt_r <= 1'b0;
      testLoadEn_r <= 1'b0;
      dpSrcEn_r <= 1'b0;
      dmPullDnEn_r <= 1'b0;
      dpVoltSrcEn_r <= 1'b0;
      dmSinkEn_r <= 1'b0;
      regulatorEn_r <= 1'b0;
      converterEn_r <= 1'b0;
      batterySwitchOn_r <= 1'b1;
      boostEn_r <= 1'b0;
      inputLimit_r <= `ISD_LIM_100;
      minSysSel_r <= `ISD_RST_MINSYS;
    end else begin
      state_r <= stateNxt;
      if (qualPass) begin
        pgood_r <= 1'b1;
      end else if (!vbusPresent) begin
        pgood_r <= 1'b0;
      end
      srcType_r <= srcTypeNxt;
      minSysReg_r <= sysInMinReg;
      statusPrev_r <= {srcType_r, pgood_r};
      hostInt_r <= ({srcType_r, pgood_r} != statusPrev_r);
      testLoadEn_r <= (stateNxt == ST_QUAL);
      dpSrcEn_r <= (stateNxt == ST_DCD);
      dmPullDnEn_r <= (stateNxt == ST_DCD);
      dpVoltSrcEn_r <= (stateNxt == ST_PRIM);
      dmSinkEn_r <= (stateNxt == ST_PRIM);
      regulatorEn_r <= (stateNxt != ST_HIZ) && (stateNxt != ST_IDLE);
      converterEn_r <= (stateNxt == ST_RUN);
      batterySwitchOn_r <= !((stateNxt == ST_RUN) && !chgEn);
      boostEn_r <= (stateNxt == ST_BOOST);
      inputLimit_r <= sysBelowSoftStart ? `ISD_LIM_100 : pinOrReg;
      minSysSel_r <= minSys_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file
  assign wrEn = psel && penable && pready && pwrite && mapped;

  always @* begin
    rdVal = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `ISD_OFS_INPUT: begin
        rdVal[`ISD_HIZ_BIT] = hizCtrl_r;
        rdVal[`ISD_LIM_MSB:0] = limitField_r;
      end
      `ISD_OFS_POWER: begin
        rdVal[`ISD_CFG_MSB:`ISD_CFG_LSB] = chgCfg_r;
        rdVal[`ISD_MINSYS_MSB:`ISD_MINSYS_LSB] = minSys_r;
        rdVal[`ISD_LOWBAT_BIT] = lowBatSel_r;
      end
      `ISD_OFS_MISC: begin
        rdVal[`ISD_FORCE_BIT] = forceDet_r;
        rdVal[`ISD_HOSTMODE_BIT] = hostMode_r;
      end
      `ISD_OFS_STATUS: begin
        rdVal[`ISD_SRC_MSB:`ISD_SRC_LSB] = srcType_r;
        rdVal[`ISD_PG_BIT] = pgood_r;
        rdVal[`ISD_BOOST_BIT] = (state_r == ST_BOOST);
        rdVal[`ISD_MINREG_BIT] = minSysReg_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // One wait-free access cycle: answer is prepared at the setup edge
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rdVal;
      pready <= 1'b1;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hizCtrl_r <= 1'b0;
      limitField_r <= `ISD_RST_LIM;
      chgCfg_r <= `ISD_RST_CFG;
      minSys_r <= `ISD_RST_MINSYS;
      lowBatSel_r <= 1'b0;
      forceDet_r <= 1'b0;
      hostMode_r <= 1'b0;
    end else begin
      if (wrEn && (paddr == `ISD_OFS_INPUT)) begin
        hizCtrl_r <= pwdata[`ISD_HIZ_BIT];
        limitField_r <= pwdata[`ISD_LIM_MSB:0];
      end else if (!hostMode_r && !vbusPresent) begin
        hizCtrl_r <= 1'b0;
      end
      // Hardware set wins over any software value in the same cycle
      if (detHiz) begin
        hizCtrl_r <= 1'b1;
      end
      if (detDone) begin
        limitField_r <= detLimit;
      end
      if (wrEn && (paddr == `ISD_OFS_POWER)) begin
        chgCfg_r <= pwdata[`ISD_CFG_MSB:`ISD_CFG_LSB];
        minSys_r <= pwdata[`ISD_MINSYS_MSB:`ISD_MINSYS_LSB];
        lowBatSel_r <= pwdata[`ISD_LOWBAT_BIT];
      end
      if (wrEn && (paddr == `ISD_OFS_MISC)) begin
        forceDet_r <= pwdata[`ISD_FORCE_BIT];
        hostMode_r <= pwdata[`ISD_HOSTMODE_BIT];
      end else if (detDone) begin
        forceDet_r <= 1'b0;
      end
    end
  end
endmodule // isd_input_detect
`default_nettype wire

//--- test/isd_input_detect_monitor.sv
// Port checker for the input source detect sequencer
`timescale 1ns/10ps
`default_nettype none
module isd_input_detect_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Comparators and pins
  input wire logic vbusPresent,
  input wire logic sysBelowSoftStart,
  input wire logic boostRequestPin,
  // Controls
  input wire logic dpSrcEn_r,
  input wire logic dmPullDnEn_r,
  input wire logic dpVoltSrcEn_r,
  input wire logic dmSinkEn_r,
  input wire logic converterEn_r,
  input wire logic batterySwitchOn_r,
  input wire logic boostEn_r,
  input wire logic [2:0] inputLimit_r,
  input wire logic hostInt_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////
  a_dcd_pair: assert property (dpSrcEn_r == dmPullDnEn_r)
    else $error("contact detect enables differ");
  a_prim_pair: assert property (dpVoltSrcEn_r == dmSinkEn_r)
    else $error("primary detect enables differ");
  a_step_order: assert property (!(dpSrcEn_r && dpVoltSrcEn_r))
    else $error("both detection steps driven");
  a_dcd_start: assert property ($rose(dpSrcEn_r) |-> $past(vbusPresent))
    else $error("contact detect without supply");
  a_int_pulse: assert property (hostInt_r |=> !hostInt_r)
    else $error("interrupt longer than one cycle");
  a_soft_start: assert property (sysBelowSoftStart |=> inputLimit_r == 3'h0)
    else $error("limit not forced low in soft start");
  a_boost_gate: assert property (!boostRequestPin [*4] |-> !boostEn_r)
    else $error("boost without request pin");
  a_switch_run: assert property (!batterySwitchOn_r |-> converterEn_r)
    else $error("battery switch off outside run");
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not a single cycle");
  a_bad_addr: assert property (psel && !penable && paddr > 8'h0C |=> pslverr)
    else $error("unmapped access not refused");
endmodule // isd_input_detect_monitor
bind isd_input_detect isd_input_detect_monitor isd_input_detect_monitor_i (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .vbusPresent(vbusPresent),
  .sysBelowSoftStart(sysBelowSoftStart), .boostRequestPin(boostRequestPin),
  .dpSrcEn_r(dpSrcEn_r), .dmPullDnEn_r(dmPullDnEn_r), .dpVoltSrcEn_r(dpVoltSrcEn_r),
  .dmSinkEn_r(dmSinkEn_r), .converterEn_r(converterEn_r),
  .batterySwitchOn_r(batterySwitchOn_r), .boostEn_r(boostEn_r),
  .inputLimit_r(inputLimit_r), .hostInt_r(hostInt_r)
);
`default_nettype wire

//--- test/isd_usb_port_model.sv
// Behavioural USB port seen through the data line comparators
`timescale 1ns/10ps
`default_nettype none
module isd_usb_port_model (
  // Clock
  input wire logic mclk,
  // Setup: 0 floating, 1 host, 2 charging port
  input wire logic [1:0] portKind,
  input wire logic [7:0] contactDelay,
  // Charger drives
  input wire logic dpSrcEn,
  input wire logic dpVoltSrcEn,
  // Comparators
  output logic dpLow,
  output logic dmHigh
);
  logic [7:0] cnt_r = 8'h00;
  logic tog_r = 1'b0;
  always @(posedge mclk) begin
    cnt_r <= dpSrcEn ? cnt_r + 8'h01 : 8'h00;
    tog_r <= !tog_r;
  end
  // Floating lines wander, so an idle comparator never reads a steady level
  always_comb begin
    if (portKind == 2'h0) begin
      dpLow = dpSrcEn ? 1'b0 : tog_r;
      dmHigh = !tog_r;
    end else begin
      dpLow = !dpSrcEn || cnt_r >= contactDelay;
      dmHigh = portKind == 2'h2 && dpVoltSrcEn;
    end
  end
endmodule // isd_usb_port_model
`default_nettype wire

//--- test/isd_input_detect_test.sv
// Self-checking bench for the input source detect sequencer
`timescale 1ns/10ps
`default_nettype none
module isd_input_detect_test;
  logic mclk, sys_rst, psel, penable, pwrite, err, pin;
  logic [7:0] paddr, contactDelay;
  logic [31:0] pwdata, rd;
  logic vbusPresent, vbusOverVolt, vbusWeak, vbusBelowSleep, batAboveGood;
  logic batAboveLowA, batAboveLowB, sysBelowSoftStart, sysInMinReg, boostRequestPin;
  logic [2:0] currentLimitPin, e;
  logic [1:0] portKind, k;
  wire [31:0] prdata;
  wire pready, pslverr, dpLow, dmHigh, testLoadEn, dpSrcEn, dmPullDnEn, dpVoltSrcEn;
  wire dmSinkEn, regulatorEn, converterEn, batterySwitchOn, boostEn, hostInt;
  wire [2:0] inputLimit, minSysSel;
  int fail_count, comparisons, intCount, n;
  int expQ[$];
  isd_input_detect #(.RETRY_CYC(32'd200), .DCD_MIN_CYC(32'd20), .DCD_MAX_CYC(32'd60),
    .PRIM_CYC(32'd20), .BOOST_CYC(32'd40)) isd_input_detect_i (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbusPresent(vbusPresent), .vbusOverVolt(vbusOverVolt), .vbusWeak(vbusWeak),
    .vbusBelowSleep(vbusBelowSleep), .batAboveGood(batAboveGood),
    .batAboveLowA(batAboveLowA), .batAboveLowB(batAboveLowB),
    .sysBelowSoftStart(sysBelowSoftStart),
    .sysInMinReg(sysInMinReg), .dpLow(dpLow), .dmHigh(dmHigh),
    .boostRequestPin(boostRequestPin), .currentLimitPin(currentLimitPin),
    .testLoadEn_r(testLoadEn), .dpSrcEn_r(dpSrcEn), .dmPullDnEn_r(dmPullDnEn),
    .dpVoltSrcEn_r(dpVoltSrcEn), .dmSinkEn_r(dmSinkEn), .regulatorEn_r(regulatorEn),
    .converterEn_r(converterEn), .batterySwitchOn_r(batterySwitchOn), .boostEn_r(boostEn),
    .inputLimit_r(inputLimit), .minSysSel_r(minSysSel), .hostInt_r(hostInt));
  isd_usb_port_model isd_usb_port_model_i (.mclk(mclk), .portKind(portKind),
    .contactDelay(contactDelay), .dpSrcEn(dpSrcEn), .dpVoltSrcEn(dpVoltSrcEn),
    .dpLow(dpLow), .dmHigh(dmHigh));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (hostInt === 1'b1) intCount++;
  ////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Waits on pready without a limit of its own; the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wconv();
    repeat (400) if (converterEn !== 1'b1) @(posedge mclk);
  endtask
  task automatic attach(input logic [1:0] kk, input logic p);
    portKind <= kk; boostRequestPin <= p; intCount = 0;
    currentLimitPin <= 3'($urandom % 8); contactDelay <= 8'($urandom % 30);
    vbusPresent <= 1'b1;
    @(posedge mclk);
    wconv();
  endtask
  task automatic detach();
    vbusPresent <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    give_verdict;
  end
  ////////////////////
  initial begin
    {psel, penable, pwrite, vbusPresent, vbusOverVolt, vbusWeak, vbusBelowSleep} = '0;
    {batAboveGood, batAboveLowA, batAboveLowB, sysBelowSoftStart, sysInMinReg} = '0;
    boostRequestPin = 1'b0;
    paddr = '0; pwdata = '0; currentLimitPin = 3'h7; portKind = 2'h1; contactDelay = 8'h05;
    fail_count = 0; comparisons = 0; intCount = 0; sys_rst = 1'b1;
    rd = $urandom(79);
    // Expected limit codes per attach: floating, host pin low, host pin high, port
    for (int i = 0; i < 4; i++) expQ.push_back((i == 3) ? 5 : (i == 2) ? 2 : 0);
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(0, 8'h00, 0); chk("input_reg", rd, 32'h00);
    apb(0, 8'h04, 0); chk("power_reg", rd, 32'h1A);
    apb(0, 8'h08, 0); chk("misc_reg", rd, 32'h00);
    apb(0, 8'h0C, 0); chk("status_reg", rd, 32'h00);
    apb(0, 8'h10, 0); chk("unmapped_err", err, 1);
    chk("min_sys_sel", minSysSel, 3'h5);
    for (int i = 0; i < 4; i++) begin
      k = (i == 3) ? 2'h2 : (i == 0) ? 2'h0 : 2'h1;
      pin = (i == 2);
      e = 3'(expQ.pop_front());
      attach(k, pin);
      apb(0, 8'h0C, 0);
      chk("src_type", rd[7:6], k);
      chk("power_good", rd[2], 1);
      apb(0, 8'h00, 0); chk("limit_field", rd[2:0], e);
      chk("eff_limit", inputLimit, currentLimitPin < e ? currentLimitPin : e);
      chk("int_seen", intCount > 0, 1);
      chk("bat_switch", batterySwitchOn, 1);
      detach();
    end
    vbusWeak <= 1'b1; vbusPresent <= 1'b1;
    repeat (100) @(posedge mclk);
    apb(0, 8'h0C, 0); chk("weak_pg", rd[2], 0);
    vbusWeak <= 1'b0; n = 0;
    while (dpSrcEn !== 1'b1 && n < 300) begin n++; @(posedge mclk); end
    chk("retry_span", n >= 80 && n <= 150, 1);
    wconv(); detach();
    vbusOverVolt <= 1'b1; vbusPresent <= 1'b1;
    repeat (300) @(posedge mclk);
    apb(0, 8'h0C, 0); chk("ov_pg", rd[2], 0);
    chk("test_load", testLoadEn, 1);
    vbusOverVolt <= 1'b0;
    wconv(); chk("ov_clear", converterEn, 1);
    chk("load_off", testLoadEn, 0);
    detach();
    apb(1, 8'h08, 32'h01); batAboveGood <= 1'b1;
    attach(1, 0);
    apb(0, 8'h00, 0); chk("hiz_bit", rd[7], 1);
    chk("regulator_off", regulatorEn, 0);
    vbusPresent <= 1'b0; repeat (10) @(posedge mclk);
    vbusPresent <= 1'b1; n = 0;
    repeat (100) begin @(posedge mclk); if (dpSrcEn === 1'b1) n++; end
    chk("no_redetect", n, 0);
    batAboveGood <= 1'b0; apb(1, 8'h00, 0);
    wconv(); chk("hiz_exit", converterEn, 1);
    detach(); apb(1, 8'h08, 32'h00); batAboveGood <= 1'b1;
    attach(1, 0); detach();
    apb(0, 8'h00, 0); chk("hiz_removed", rd[7], 0);
    batAboveGood <= 1'b0;
    attach(2, 0);
    apb(1, 8'h08, 32'h80);
    repeat (50) if (dpSrcEn !== 1'b1) @(posedge mclk);
    chk("force_rerun", dpSrcEn, 1);
    repeat (200) if (dmSinkEn !== 1'b1) @(posedge mclk);
    repeat (100) if (dmSinkEn !== 1'b0) @(posedge mclk);
    repeat (5) @(posedge mclk);
    apb(0, 8'h08, 0); chk("force_clear", rd[7], 0);
    apb(1, 8'h00, 32'h02); repeat (2) @(posedge mclk);
    chk("sw_limit", inputLimit, currentLimitPin < 3'h2 ? currentLimitPin : 3'h2);
    sysBelowSoftStart <= 1'b1; repeat (3) @(posedge mclk);
    chk("soft_limit", inputLimit, 3'h0);
    sysBelowSoftStart <= 1'b0; sysInMinReg <= 1'b1;
    apb(1, 8'h04, 32'h06); repeat (2) @(posedge mclk);
    chk("bat_off", batterySwitchOn, 0);
    chk("min_sys_new", minSysSel, 3'h3);
    apb(0, 8'h0C, 0); chk("min_reg_bit", rd[0], 1);
    sysInMinReg <= 1'b0; detach();
    // Second low-battery choice: only the B comparator may enable boost
    apb(1, 8'h04, 32'h2B); batAboveLowA <= 1'b1; vbusBelowSleep <= 1'b1;
    boostRequestPin <= 1'b1; repeat (60) @(posedge mclk);
    chk("boost_lowsel", boostEn, 0);
    batAboveLowB <= 1'b1; repeat (20) @(posedge mclk);
    chk("boost_early", boostEn, 0);
    repeat (40) @(posedge mclk);
    chk("boost_on", boostEn, 1);
    apb(0, 8'h0C, 0); chk("boost_src", {rd[7:6], rd[1]}, 3'h7);
    boostRequestPin <= 1'b0; repeat (6) @(posedge mclk);
    chk("boost_off", boostEn, 0);
    give_verdict;
  end
endmodule // isd_input_detect_test
`default_nettype wire
